/* design/psfi_fault_inject.v */
`timescale 1ns/1ps
`default_nettype none
`include "psfi_regs.vh"
module psfi_fault_inject #(
	parameter TIMEOUT_CYC = `PSFI_TIMEOUT_CYC, // test mode time-out
	parameter DESATURATION_DETECT_BLANK = `PSFI_DESATURATION_DETECT_BLANK_CYC, // desaturation_detect blanking
	parameter OCP_BLANK = `PSFI_OCP_BLANK_CYC // overcurrent blanking
) (
	input wire mclk,
	input wire rst_b,
	input wire [3:0] regAddr,
	input wire [15:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [15:0] regRdata,
	input wire pwmCommandInput,
	input wire desatCmpIn,
	input wire [1:0] ocpCmpIn,
	input wire [3:0] supplyFaultIn,
	output reg gateOnStrong,
	output reg gateOnWeak,
	output reg desatErr,
	output reg ocpErr,
	output reg [3:0] supplyErr,
	output reg [4:0] modeState
);
	// ----------------------------------------------------------------
	// mode states, one-hot
	// ----------------------------------------------------------------
	localparam [4:0] ST_DEFAULT = 5'h01; // default_mode
	localparam [4:0] ST_CONFIG = 5'h02; // configuration_mode
	localparam [4:0] ST_ACTIVE = 5'h04; // normally active
	localparam [4:0] ST_VERIFY = 5'h08; // verification_mode
	localparam [4:0] ST_WEAK = 5'h10; // weak_active_mode

	// blanking countdown from its load value
	function [15:0] psfiCount;
		input [15:0] cnt;
		input start;
		input [31:0] load;
		begin
			if (start) begin
				psfiCount = load[15:0]; // blanking counts fit 16 bits
			end else if (cnt != 16'h0000) begin
				psfiCount = cnt - 16'h0001;
			end else begin
				psfiCount = cnt;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [7:0] pinMeta_r; // first stage, read only by second
	reg [7:0] pinSync_r; // second stage
	always @(posedge mclk) begin
		if (!rst_b) begin
			pinMeta_r <= 8'h00;
			pinSync_r <= 8'h00;
		end else begin
			pinMeta_r <= {supplyFaultIn, ocpCmpIn, desatCmpIn,
				pwmCommandInput};
			pinSync_r <= pinMeta_r;
		end
	end
	wire pwmS = pinSync_r[0]; // synced pwm command
	wire desatS = pinSync_r[1]; // synced desaturation_detect comparator
	wire [1:0] ocpS = pinSync_r[3:2]; // synced ocp comparators
	wire [3:0] supS = pinSync_r[7:4]; // synced supply monitors

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	reg [4:0] state_r; // current mode
	reg [4:0] state_nxt;
	reg unlock_r; // key sequence seen since reset
	reg keyHalf_r; // first key word seen
	reg [2:0] supSel_r; // primary supervision select
	reg [1:0] desatLvl_r; // secondary select, desaturation_detect level
	reg [1:0] ocpLvl_r; // secondary select, ocp level
	reg [2:0] supAct_r; // applied supply test
	reg [1:0] desatAct_r; // applied desaturation_detect level
	reg [1:0] ocpAct_r; // applied ocp level
	reg [31:0] tmo_r; // test mode time-out counter
	reg pwmD_r; // pwm delayed for edge detect
	reg [15:0] dBlank_r; // desaturation_detect blanking countdown
	reg [15:0] oBlank_r; // ocp blanking countdown
	reg dArmed_r; // desaturation_detect blanking running or done
	reg oArmed_r; // ocp blanking running or done
	reg [4:0] prevState_r; // state one cycle back

	wire wrMode = regWr && (regAddr == `PSFI_ADDR_MODE);
	wire wrKey = regWr && (regAddr == `PSFI_ADDR_KEY);
	wire wrStat = regWr && (regAddr == `PSFI_ADDR_STAT);
	wire [2:0] req = regWdata[2:0];
	wire inTest = (state_r == ST_VERIFY) || (state_r == ST_WEAK);
	wire inWeak = (state_r == ST_WEAK);
	wire tmoHit = inTest && (tmo_r == TIMEOUT_CYC - 1);
	wire weakEntry = inWeak && (prevState_r != ST_WEAK);
	wire pwmRise = pwmS && !pwmD_r;

	// ----------------------------------------------------------------
	// mode state machine
	// ----------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_DEFAULT: begin
				if (wrMode && req == `PSFI_REQ_CONFIG) begin
					state_nxt = ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				if (wrMode && req == `PSFI_REQ_ACTIVE) begin
					state_nxt = ST_ACTIVE;
				end else if (wrMode && req == `PSFI_REQ_VERIFY &&
					unlock_r) begin
					state_nxt = ST_VERIFY;
				end else if (wrMode && req == `PSFI_REQ_DEFAULT) begin
					state_nxt = ST_DEFAULT;
				end
			end
			ST_ACTIVE: begin
				// no route from here into a test mode
				if (wrMode && req == `PSFI_REQ_CONFIG) begin
					state_nxt = ST_CONFIG;
				end
			end
			ST_VERIFY: begin
				if (tmoHit) begin
					state_nxt = ST_DEFAULT;
				end else if (wrMode && req == `PSFI_REQ_WEAK) begin
					state_nxt = ST_WEAK;
				end else if (wrMode && req == `PSFI_REQ_DEFAULT) begin
					state_nxt = ST_DEFAULT;
				end
			end
			ST_WEAK: begin
				if (tmoHit || (wrMode && req == `PSFI_REQ_DEFAULT)) begin
					state_nxt = ST_DEFAULT;
				end
			end
			default: begin
				state_nxt = ST_DEFAULT;
			end
		endcase
	end

	// state, key sequence, selections and time-out
	always @(posedge mclk) begin
		if (!rst_b) begin
			state_r <= ST_DEFAULT;
			prevState_r <= ST_DEFAULT;
			unlock_r <= 1'b0;
			keyHalf_r <= 1'b0;
			supSel_r <= 3'h0;
			desatLvl_r <= 2'h0;
			ocpLvl_r <= 2'h0;
			supAct_r <= 3'h0;
			desatAct_r <= 2'h0;
			ocpAct_r <= 2'h0;
			tmo_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			prevState_r <= state_r;
			// two key words on consecutive writes, any other write breaks it
			if (wrKey && keyHalf_r && regWdata == `PSFI_KEY_SECOND) begin
				unlock_r <= 1'b1;
			end
			// idle cycles between the two writes keep the first half
			if (regWr) begin
				keyHalf_r <= wrKey && (regWdata == `PSFI_KEY_FIRST);
			end
			// selections are writable in configuration only
			if (regWr && state_r == ST_CONFIG) begin
				if (regAddr == `PSFI_ADDR_PSUP) begin
					supSel_r <= regWdata[`PSFI_PSUP_SEL_LSB +: 3];
				end
				if (regAddr == `PSFI_ADDR_SSUP) begin
					desatLvl_r <= regWdata[`PSFI_SSUP_DESATURATION_DETECT_LSB +: 2];
					ocpLvl_r <= regWdata[`PSFI_SSUP_OCP_LSB +: 2];
				end
			end
			// applied on entry to verification, kept in weak-active, dropped on return to default
			if (state_nxt == ST_VERIFY && state_r == ST_CONFIG) begin
				supAct_r <= supSel_r;
				desatAct_r <= desatLvl_r;
				ocpAct_r <= ocpLvl_r;
			end else if (state_nxt != ST_VERIFY && state_nxt != ST_WEAK) begin
				supAct_r <= 3'h0;
				desatAct_r <= 2'h0;
				ocpAct_r <= 2'h0;
			end
			// time-out runs across verification and weak-active
			if (inTest && state_nxt != ST_DEFAULT) begin
				tmo_r <= tmo_r + 32'h00000001;
			end else begin
				tmo_r <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// fault forcing and output forwarding
	// ----------------------------------------------------------------
	wire dL1 = (desatAct_r == 2'h1);
	wire dL2 = (desatAct_r == 2'h2);
	wire dL3 = (desatAct_r == 2'h3);
	wire oL1 = (ocpAct_r == 2'h1);
	wire oL3 = (ocpAct_r == 2'h3);
	// comparator inputs pulled above threshold when forced
	wire desatSense = desatS || dL1 || dL3;
	wire ocpSense = (|ocpS) || oL1 || oL3;
	// pwm kept off the output stage for these levels
	wire blockOut = dL2 || dL3 || oL3;
	wire anyErr = desatErr || ocpErr || (|supplyErr);
	wire dBlankDone = dArmed_r && (dBlank_r == 16'h0000);
	wire oBlankDone = oArmed_r && (oBlank_r == 16'h0000);
	// injected supply fault for the addressed monitor only
	reg [3:0] supInj;
	always @* begin
		supInj = 4'h0;
		if (state_r == ST_VERIFY) begin
			case (supAct_r)
				`PSFI_SUP_UV2: supInj = 4'h1;
				`PSFI_SUP_OV2: supInj = 4'h2;
				`PSFI_SUP_UV3: supInj = 4'h4;
				`PSFI_SUP_OV3: supInj = 4'h8;
				default: supInj = 4'h0;
			endcase
		end
	end

	// blanking, error flags and gate drive
	always @(posedge mclk) begin
		if (!rst_b) begin
			pwmD_r <= 1'b0;
			dBlank_r <= 16'h0000;
			oBlank_r <= 16'h0000;
			dArmed_r <= 1'b0;
			oArmed_r <= 1'b0;
			desatErr <= 1'b0;
			ocpErr <= 1'b0;
			supplyErr <= 4'h0;
			gateOnStrong <= 1'b0;
			gateOnWeak <= 1'b0;
		end else begin
			pwmD_r <= pwmS;
			// blanking starts on a turn-on command, even undriven
			dBlank_r <= psfiCount(dBlank_r, pwmRise, DESATURATION_DETECT_BLANK);
			oBlank_r <= psfiCount(oBlank_r, pwmRise, OCP_BLANK);
			dArmed_r <= pwmS && (dArmed_r || pwmRise);
			oArmed_r <= pwmS && (oArmed_r || pwmRise);
			// errors are sticky; a new event wins over the clear
			if ((dBlankDone && desatSense) || (weakEntry && dL3)) begin
				desatErr <= 1'b1;
			end else if (wrStat && regWdata[`PSFI_STAT_DESATURATION_DETECT]) begin
				desatErr <= 1'b0;
			end
			if ((oBlankDone && ocpSense) || (weakEntry && oL3)) begin
				ocpErr <= 1'b1;
			end else if (wrStat && regWdata[`PSFI_STAT_OCP]) begin
				ocpErr <= 1'b0;
			end
			supplyErr <= (supplyErr & ~(wrStat ?
				regWdata[`PSFI_STAT_SUP_LSB +: 4] : 4'h0)) |
				supS | supInj;
			// gate drive: full in active, weak in weak-active
			gateOnStrong <= (state_r == ST_ACTIVE) && pwmS && !anyErr;
			gateOnWeak <= inWeak && pwmS && !blockOut && !anyErr;
		end
	end

	// ----------------------------------------------------------------
	// register read port, data one cycle after strobe
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (!rst_b) begin
			regRdata <= 16'h0000;
			modeState <= ST_DEFAULT;
		end else begin
			modeState <= state_r;
			if (regRd) begin
				case (regAddr)
					`PSFI_ADDR_MODE: regRdata <= {11'h000, state_r};
					`PSFI_ADDR_PSUP: regRdata <= {13'h0000, supSel_r};
					`PSFI_ADDR_SSUP: regRdata <= {12'h000, ocpLvl_r,
						desatLvl_r};
					`PSFI_ADDR_STAT: regRdata <= {3'h0, state_r, 1'b0,
						unlock_r, supplyErr, ocpErr, desatErr};
					default: regRdata <= 16'h0000;
				endcase
			end else begin
				regRdata <= 16'h0000;
			end
		end
	end
endmodule // psfi_fault_inject
`default_nettype wire

/* design/psfi_regs.vh */
`ifndef PSFI_REGS_VH
`define PSFI_REGS_VH
// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define PSFI_ADDR_MODE 4'h0
`define PSFI_ADDR_KEY 4'h1
`define PSFI_ADDR_PSUP 4'h2
`define PSFI_ADDR_SSUP 4'h3
`define PSFI_ADDR_STAT 4'h4
// ----------------------------------------------------------------
// mode request codes (mode register bits 2:0)
// ----------------------------------------------------------------
`define PSFI_REQ_DEFAULT 3'h1
`define PSFI_REQ_CONFIG 3'h2
`define PSFI_REQ_ACTIVE 3'h3
`define PSFI_REQ_VERIFY 3'h5
`define PSFI_REQ_WEAK 3'h6
// ----------------------------------------------------------------
// unlock key words, written back to back
// ----------------------------------------------------------------
`define PSFI_KEY_FIRST 16'hA55A
`define PSFI_KEY_SECOND 16'h5AA5
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSFI_SSUP_DESATURATION_DETECT_LSB 0
`define PSFI_SSUP_OCP_LSB 2
`define PSFI_PSUP_SEL_LSB 0
// supply test select codes (primary supply has no code)
`define PSFI_SUP_NONE 3'h0
`define PSFI_SUP_UV2 3'h1
`define PSFI_SUP_OV2 3'h2
`define PSFI_SUP_UV3 3'h3
`define PSFI_SUP_OV3 3'h4
// status bit positions
`define PSFI_STAT_DESATURATION_DETECT 0
`define PSFI_STAT_OCP 1
`define PSFI_STAT_SUP_LSB 2
`define PSFI_STAT_UNLOCK 6
`define PSFI_STAT_MODE_LSB 8
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSFI_CLK_MHZ 40
`define PSFI_TIMEOUT_US 1000
`define PSFI_TIMEOUT_CYC (`PSFI_TIMEOUT_US * `PSFI_CLK_MHZ)
`define PSFI_DESATURATION_DETECT_BLANK_NS 2500
`define PSFI_DESATURATION_DETECT_BLANK_CYC ((`PSFI_DESATURATION_DETECT_BLANK_NS * `PSFI_CLK_MHZ + 999) / 1000)
`define PSFI_OCP_BLANK_NS 1000
`define PSFI_OCP_BLANK_CYC ((`PSFI_OCP_BLANK_NS * `PSFI_CLK_MHZ + 999) / 1000)
`endif

/* testbench/psfi_fault_inject_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module psfi_fault_inject_checker #(
	parameter int TIMEOUT_CYC = 50
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic pwmCommandInput,
	input wire logic [3:0] supplyFaultIn,
	input wire logic gateOnStrong,
	input wire logic gateOnWeak,
	input wire logic desatErr,
	input wire logic ocpErr,
	input wire logic [3:0] supplyErr,
	input wire logic [4:0] modeState
);
	// --------
	// helpers
	// --------
	int tstCnt_r; // cycles spent in a test mode
	always @(posedge mclk) begin
		if (!rst_b || !(modeState[3] || modeState[4])) begin
			tstCnt_r <= 0;
		end else begin
			tstCnt_r <= tstCnt_r + 1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// active, no desaturation_detect or ocp error (supply errors not checked), four cycles
	sequence s_clean;
		(modeState == 5'h04 && !desatErr && !ocpErr)[*4];
	endsequence
	// no real supply fault and no verify, four cycles
	sequence s_quiet;
		(supplyFaultIn == 4'h0 && !modeState[3])[*4];
	endsequence
	// --------
	// properties
	// --------
	property p_strong;
		gateOnStrong |-> modeState[2] || $past(modeState[2]);
	endproperty
	a_strong: assert property (p_strong) else $error("strong gate");
	property p_weak;
		gateOnWeak |-> modeState[4] || $past(modeState[4]);
	endproperty
	a_weak: assert property (p_weak) else $error("weak gate");
	property p_block;
		desatErr || ocpErr |=> !gateOnStrong && !gateOnWeak;
	endproperty
	a_block: assert property (p_block) else $error("gate on error");
	property p_follow;
		s_clean |-> gateOnStrong == $past(pwmCommandInput, 3);
	endproperty
	a_follow: assert property (p_follow) else $error("pwm path");
	property p_enter;
		$rose(modeState[3]) |-> $past(modeState[1]);
	endproperty
	a_enter: assert property (p_enter) else $error("verify entry");
	property p_tmo;
		tstCnt_r <= TIMEOUT_CYC + 2;
	endproperty
	a_tmo: assert property (p_tmo) else $error("test time-out");
	property p_rdIdle;
		!$past(regRd) |-> regRdata == 16'h0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read idle");
	property p_sup;
		s_quiet ##1 !modeState[3] |-> (supplyErr & ~$past(supplyErr)) == 4'h0;
	endproperty
	a_sup: assert property (p_sup) else $error("supply error");
endmodule // psfi_fault_inject_checker
bind psfi_fault_inject psfi_fault_inject_checker #(.TIMEOUT_CYC(TIMEOUT_CYC))
	u_chk (.mclk(mclk), .rst_b(rst_b), .regRd(regRd), .regRdata(regRdata),
	.pwmCommandInput(pwmCommandInput), .supplyFaultIn(supplyFaultIn),
	.gateOnStrong(gateOnStrong), .gateOnWeak(gateOnWeak),
	.desatErr(desatErr), .ocpErr(ocpErr), .supplyErr(supplyErr),
	.modeState(modeState));
`default_nettype wire

/* testbench/psfi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psfi_regs.vh"
module psfi_host_model (
	input wire logic mclk,
	output logic [3:0] regAddr,
	output logic [15:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [15:0] regRdata,
	output logic pwmCommandInput
);
	// idle bus at time zero
	initial begin
		regAddr = 4'h0;
		regWdata = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		pwmCommandInput = 1'b0;
	end
	// one-cycle write
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// one-cycle read, data in the next cycle
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	// pwm level set on an edge
	task pwm(input logic v);
		@(posedge mclk);
		pwmCommandInput <= v;
	endtask
	// one selection, plateau held at zero
	task arm(input logic [15:0] ss, input logic [15:0] ps);
		wr(`PSFI_ADDR_MODE, 16'h0002);
		wr(`PSFI_ADDR_SSUP, ss);
		wr(`PSFI_ADDR_PSUP, ps);
		wr(`PSFI_ADDR_KEY, `PSFI_KEY_FIRST);
		wr(`PSFI_ADDR_KEY, `PSFI_KEY_SECOND);
		wr(`PSFI_ADDR_MODE, 16'h0005);
	endtask
endmodule // psfi_host_model
`default_nettype wire

/* testbench/psfi_fault_inject_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psfi_regs.vh"
module psfi_fault_inject_tb_top;
	localparam int TMO = 50; // short test-mode time-out
	logic mclk, rst_b, regWr, regRd, pwmCommandInput, desatCmpIn;
	logic [3:0] regAddr, supplyFaultIn, supplyErr;
	logic [15:0] regWdata, regRdata, rdat;
	logic [1:0] ocpCmpIn;
	logic gateOnStrong, gateOnWeak, desatErr, ocpErr, weakSeen, strongSeen;
	logic [4:0] modeState;
	int errors, samplesChecked, cyc, k;
	psfi_fault_inject #(.TIMEOUT_CYC(TMO), .DESATURATION_DETECT_BLANK(8), .OCP_BLANK(8))
		u_dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .pwmCommandInput(pwmCommandInput),
		.desatCmpIn(desatCmpIn), .ocpCmpIn(ocpCmpIn),
		.supplyFaultIn(supplyFaultIn), .gateOnStrong(gateOnStrong),
		.gateOnWeak(gateOnWeak), .desatErr(desatErr), .ocpErr(ocpErr),
		.supplyErr(supplyErr), .modeState(modeState));
	psfi_host_model u_host (.mclk(mclk), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .pwmCommandInput(pwmCommandInput));
	// undriven sense node reads high, clamped after overcurrent
	assign desatCmpIn = !(gateOnStrong || gateOnWeak || ocpErr);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// gate activity flags and hang limit
	always @(posedge mclk) begin
		weakSeen <= weakSeen | gateOnWeak;
		strongSeen <= strongSeen | gateOnStrong;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			errors = errors + 1;
			stop_test;
		end
	end
	task chk(input string w, input logic [15:0] e, input logic [15:0] g);
		samplesChecked = samplesChecked + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task rst_pulse(input int n);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (n) @(posedge mclk);
		rst_b <= 1'b1;
	endtask
	// one injection run, reset to time-out
	task run(input logic [15:0] ss, ps, input logic wk, pw,
		input logic [6:0] eSt, input logic eW);
		int i;
		rst_pulse(2);
		u_host.arm(ss, ps);
		if (wk) u_host.wr(`PSFI_ADDR_MODE, 16'h0006);
		#1 weakSeen = 1'b0;
		strongSeen = 1'b0;
		u_host.pwm(pw);
		repeat (30) @(posedge mclk);
		u_host.rd(`PSFI_ADDR_STAT, rdat);
		chk("status", {9'h000, eSt}, {9'h000, rdat[6:0]});
		chk("weak gate", {15'h0000, eW}, {15'h0000, weakSeen});
		chk("strong gate", 16'h0000, {15'h0000, strongSeen});
		for (i = 0; i < 2 * TMO && modeState !== 5'h01; i++) @(posedge mclk);
		#1 chk("mode", 16'h0001, {11'h000, modeState});
		u_host.pwm(1'b0);
		$display("case %h %h done", ss, ps);
	endtask
	initial begin
		rst_b = 1'b0;
		ocpCmpIn = 2'h0;
		supplyFaultIn = 4'h0;
		{weakSeen, strongSeen} = 2'h0;
		{errors, samplesChecked, cyc} = 0;
		rst_pulse(8);
		u_host.rd(`PSFI_ADDR_MODE, rdat);
		chk("mode reset", 16'h0001, rdat);
		u_host.rd(4'hF, rdat);
		chk("unmapped", 16'h0000, rdat);
		@(posedge mclk) supplyFaultIn <= 4'h4;
		repeat (5) @(posedge mclk);
		#1 chk("real supply", 16'h0004, {12'h000, supplyErr});
		@(posedge mclk) supplyFaultIn <= 4'h0;
		repeat (3) @(posedge mclk);
		u_host.wr(`PSFI_ADDR_STAT, 16'h003F);
		u_host.rd(`PSFI_ADDR_STAT, rdat);
		chk("cleared", 16'h0100, rdat);
		u_host.wr(`PSFI_ADDR_MODE, 16'h0002);
		u_host.wr(`PSFI_ADDR_MODE, 16'h0005);
		#1 chk("locked", 16'h0002, {11'h000, modeState});
		u_host.wr(`PSFI_ADDR_KEY, `PSFI_KEY_FIRST);
		u_host.wr(`PSFI_ADDR_KEY, 16'h1234);
		u_host.wr(`PSFI_ADDR_KEY, `PSFI_KEY_SECOND);
		u_host.wr(`PSFI_ADDR_MODE, 16'h0005);
		#1 chk("broken key", 16'h0002, {11'h000, modeState});
		u_host.wr(`PSFI_ADDR_MODE, 16'h0003);
		u_host.wr(`PSFI_ADDR_MODE, 16'h0005);
		#1 chk("active", 16'h0004, {11'h000, modeState});
		u_host.pwm(1'b1);
		repeat (6) @(posedge mclk);
		#1 chk("strong on", 16'h0001, {15'h0000, gateOnStrong});
		u_host.pwm(1'b0);
		$display("access test done");
		run(16'h0002, 16'h0000, 1'b1, 1'b1, 7'h41, 1'b0);
		run(16'h0003, 16'h0000, 1'b1, 1'b0, 7'h41, 1'b0);
		run(16'h0004, 16'h0000, 1'b1, 1'b1, 7'h42, 1'b1);
		run(16'h000C, 16'h0000, 1'b1, 1'b0, 7'h42, 1'b0);
		run(16'h0000, 16'h0000, 1'b1, 1'b1, 7'h40, 1'b1);
		for (k = 1; k < 6; k++)
			run(16'h0000, k[15:0], 1'b0, 1'b0,
				(k < 5) ? (7'h40 | (7'h02 << k)) : 7'h40, 1'b0);
		stop_test;
	end
endmodule // psfi_fault_inject_tb_top
`default_nettype wire
